// ==== verilog/pwr_enable_pkg.sv ====
// Constants and types for the power-enable, fault-clear and phase command logic
package pwr_enable_pkg;
  // Command codes
  localparam logic [7:0] CMD_ENABLE_SOURCE = 8'h02;
  localparam logic [7:0] CMD_FAULT_WIPE = 8'h03;
  localparam logic [7:0] CMD_PHASE_SELECT = 8'h04;
  // Enable-source configuration fields
  localparam int CFG_W = 5;
  localparam int CFG_DELAY_BIT = 0;
  localparam int CFG_POLARITY_BIT = 1;
  localparam int CFG_PIN_BIT = 2;
  localparam int CFG_CMD_BIT = 3;
  localparam int CFG_PU_BIT = 4;
  localparam logic [2:0] CFG_RSVD_VALUE = 3'h0;
  // Phase selection
  localparam logic [7:0] PHASE_RESET = 8'hFF;
  localparam logic [7:0] PHASE_ALL = 8'hFF;
  localparam logic [7:0] PHASE_LOOP_CTRL = 8'h00;
  localparam logic [7:0] PHASE_MAX = 8'h03;
  localparam logic [7:0] READ_UNMAPPED = 8'hFF;
  // Status byte layout
  localparam int STATUS_W = 8;
  localparam int FAULT_W = 7;
  localparam int STATUS_CML_BIT = 1;
  localparam logic [STATUS_W-1:0] STATUS_RESET = 8'h00;
  // Link transaction byte counts
  localparam logic [1:0] CNT_CMD_ONLY = 2'h1;
  localparam logic [1:0] CNT_CMD_DATA = 2'h2;
  localparam logic [1:0] CNT_OVER = 2'h3;
  localparam int TIMER_W = 16;

  typedef enum logic [1:0] {
    CONV_OFF = 2'b00,
    CONV_ON = 2'b01,
    CONV_HOLD = 2'b10,
    CONV_RAMP = 2'b11
  } conv_state_t;
endpackage

// ==== verilog/pwr_enable_cmd.sv ====
// Enable-source, fault-clear and phase-select command logic with link clock crossing
//
// Functional notes
// - Enable-source configuration at 02h, one byte, byte write and byte read.
// - Configuration bits 7:5 are read-only and always read zero.
// - Bit 4 clear: convert when input power present; set: follow pin/command.
// - Bit 3 clear ignores run command; set obeys it, with pin if enabled.
// - Bit 2 clear ignores enable pin and disables its lockout function.
// - Bit 1 selects pin polarity; active low disables lockout use.
// - Pin turn-off, bit 0 clear: hold, then ramp down; set: stop at once.
// - The enable/lockout pin is the enable pin of the configuration.
// - Invalid configuration write sets invalid-data status and notifies host.
// - Fault clear at 03h wipes status of selected phase or all phases.
// - Fault clear also releases the alert output.
// - Fault clear never restarts a converter latched off by fault.
// - A persisting fault sets its status bit again at once.
// - Alert response query drops alert but keeps status bits.
// - Sources active before the reply stay silent until cleared; new ones alert.
// - Phase selection at 04h, read/write, resets to FFh, used by later commands.
// - 00h-03h select phases one to four, FFh all, 04h-FEh invalid.
// - Phase unsupported by stacking configuration flags invalid data.
// - Grounded follower pin means phase 00h; followers use stack position.
// - Run command bit enables conversion only when configuration obeys it.
module pwr_enable_cmd (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic link_clk_i,
  input wire logic link_start_i,
  input wire logic link_byte_valid_i,
  input wire logic [7:0] link_byte_i,
  input wire logic link_stop_i,
  input wire logic link_write_i,
  input wire logic link_rd_req_i,
  input wire logic [7:0] link_rd_cmd_i,
  output logic [7:0] link_rd_data_o,
  input wire logic link_ara_i,
  output logic alert_n_o,
  input wire logic [pwr_enable_pkg::CFG_W-1:0] cfg_nvm_i,
  input wire logic input_power_ok_i,
  input wire logic enable_lockout_pin_i,
  input wire logic run_on_i,
  input wire logic latched_off_i,
  input wire logic [pwr_enable_pkg::FAULT_W-1:0] fault_src_i,
  input wire logic follower_select_pin_i,
  input wire logic [1:0] stack_position_i,
  input wire logic [1:0] stack_size_i,
  input wire logic [pwr_enable_pkg::TIMER_W-1:0] turnoff_hold_time_i,
  input wire logic [pwr_enable_pkg::TIMER_W-1:0] turnoff_ramp_time_i,
  output logic convert_en_o,
  output logic ramp_down_o,
  output logic lockout_active_o,
  output logic [7:0] phase_select_o,
  output logic phase_match_o,
  output logic [7:0] own_phase_o,
  output logic [pwr_enable_pkg::STATUS_W-1:0] status_o
);
  import pwr_enable_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain state

  typedef struct packed {
    logic [1:0] cnt;
    logic [7:0] cmd;
    logic [7:0] dat;
    logic [1:0] tx_cnt;
    logic [7:0] tx_cmd;
    logic [7:0] tx_dat;
    logic req_tgl;
    logic ara_tgl;
    logic snap_s1;
    logic snap_s2;
    logic snap_s3;
    logic [CFG_W-1:0] cfg_m;
    logic [7:0] phase_m;
    logic [7:0] rd_data;
  } link_t;

  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic req_s3;
    logic ara_s1;
    logic ara_s2;
    logic ara_s3;
    logic ack_s1;
    logic ack_s2;
    logic snap_tgl;
    logic [CFG_W-1:0] snap_cfg;
    logic [7:0] snap_phase;
    logic [1:0] pin_s;
    logic [1:0] pwr_s;
    logic [1:0] latch_s;
    logic [FAULT_W-1:0] flt_s1;
    logic [FAULT_W-1:0] flt_s2;
    logic booted;
    logic [7:0] own_phase;
    logic [7:0] max_phase;
    logic [CFG_W-1:0] cfg;
    logic [7:0] phase;
    logic [STATUS_W-1:0] status;
    logic [STATUS_W-1:0] ara_block;
    logic alert;
    conv_state_t state;
    logic [TIMER_W-1:0] timer;
  } sys_t;

  link_t l_q, l_d;
  sys_t s_q, s_d;

  // Byte a read returns for a command, from whichever copy the caller holds
  function automatic logic [7:0] read_byte(input logic [7:0] cmd,
                                           input logic [CFG_W-1:0] cfg,
                                           input logic [7:0] phase);
    logic [7:0] r;
    r = READ_UNMAPPED;
    if (cmd == CMD_ENABLE_SOURCE) begin
      r = {CFG_RSVD_VALUE, cfg};
    end else if (cmd == CMD_PHASE_SELECT) begin
      r = phase;
    end
    return r;
  endfunction

  always_comb begin
    l_d = l_q;
    l_d.snap_s1 = s_q.snap_tgl;
    l_d.snap_s2 = l_q.snap_s1;
    if (l_q.snap_s2 != l_q.snap_s3) begin
      // Snapshot words are stable while the toggle is in flight
      l_d.cfg_m = s_q.snap_cfg;
      l_d.phase_m = s_q.snap_phase;
      l_d.snap_s3 = l_q.snap_s2;
    end
    if (link_start_i) begin
      l_d.cnt = 2'h0;
    end else if (link_byte_valid_i) begin
      if (l_q.cnt == 2'h0) begin
        l_d.cmd = link_byte_i;
      end else if (l_q.cnt == 2'h1) begin
        l_d.dat = link_byte_i;
      end
      if (l_q.cnt != CNT_OVER) begin
        l_d.cnt = l_q.cnt + 2'h1;
      end
    end
    if (link_stop_i && link_write_i && l_q.cnt != 2'h0) begin
      l_d.tx_cnt = l_q.cnt;
      l_d.tx_cmd = l_q.cmd;
      l_d.tx_dat = l_q.dat;
      l_d.req_tgl = ~l_q.req_tgl;
    end
    if (link_ara_i) begin
      l_d.ara_tgl = ~l_q.ara_tgl;
    end
    if (link_rd_req_i) begin
      l_d.rd_data = read_byte(link_rd_cmd_i, l_q.cfg_m, l_q.phase_m);
    end
  end

  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      l_q <= '0;
      l_q.cfg_m <= '0;
      l_q.phase_m <= PHASE_RESET;
    end else begin
      l_q <= l_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System domain

  logic cmd_event;
  logic ara_event;
  logic pin_active;
  logic want_on;
  logic pin_off;
  logic is_wipe;
  logic wipe_hits;
  logic cfg_bad;
  logic phase_bad;
  logic cml_event;
  logic [STATUS_W-1:0] set_vec;
  logic [STATUS_W-1:0] clr_vec;

  always_comb begin
    cmd_event = s_q.req_s2 != s_q.req_s3;
    ara_event = s_q.ara_s2 != s_q.ara_s3;
    // Enable/lockout pin is the controlling pin; polarity picks its level
    pin_active = s_q.cfg[CFG_POLARITY_BIT] ? s_q.pin_s[1] : ~s_q.pin_s[1];
    if (!s_q.cfg[CFG_PU_BIT]) begin
      want_on = s_q.pwr_s[1];
    end else begin
      // Each obey bit adds its own condition; both set means both needed
      want_on = s_q.pwr_s[1]
        && (!s_q.cfg[CFG_CMD_BIT] || run_on_i)
        && (!s_q.cfg[CFG_PIN_BIT] || pin_active);
    end
    pin_off = s_q.cfg[CFG_PU_BIT] && s_q.cfg[CFG_PIN_BIT] && !pin_active
      && s_q.pwr_s[1] && (!s_q.cfg[CFG_CMD_BIT] || run_on_i);
    is_wipe = cmd_event && l_q.tx_cmd == CMD_FAULT_WIPE && l_q.tx_cnt == CNT_CMD_ONLY;
    wipe_hits = is_wipe && (s_q.phase == PHASE_ALL || s_q.phase == s_q.own_phase);
    cfg_bad = l_q.tx_dat[7:CFG_W] != CFG_RSVD_VALUE;
    phase_bad = l_q.tx_dat != PHASE_ALL && l_q.tx_dat > s_q.max_phase;
    cml_event = 1'b0;
    if (cmd_event) begin
      case (l_q.tx_cmd)
        CMD_ENABLE_SOURCE: cml_event = l_q.tx_cnt != CNT_CMD_DATA || cfg_bad;
        CMD_PHASE_SELECT: cml_event = l_q.tx_cnt != CNT_CMD_DATA || phase_bad;
        CMD_FAULT_WIPE: cml_event = l_q.tx_cnt != CNT_CMD_ONLY;
        default: cml_event = 1'b1;
      endcase
    end
    set_vec = {s_q.flt_s2[FAULT_W-1:1], 1'b0, s_q.flt_s2[0]};
    set_vec[STATUS_CML_BIT] = cml_event;
    clr_vec = wipe_hits ? {STATUS_W{1'b1}} : '0;
  end

  always_comb begin
    s_d = s_q;
    s_d.req_s1 = l_q.req_tgl;
    s_d.req_s2 = s_q.req_s1;
    s_d.req_s3 = s_q.req_s2;
    s_d.ara_s1 = l_q.ara_tgl;
    s_d.ara_s2 = s_q.ara_s1;
    s_d.ara_s3 = s_q.ara_s2;
    s_d.ack_s1 = l_q.snap_s3;
    s_d.ack_s2 = s_q.ack_s1;
    s_d.pin_s = {s_q.pin_s[0], enable_lockout_pin_i};
    s_d.pwr_s = {s_q.pwr_s[0], input_power_ok_i};
    s_d.latch_s = {s_q.latch_s[0], latched_off_i};
    s_d.flt_s1 = fault_src_i;
    s_d.flt_s2 = s_q.flt_s1;

    if (!s_q.booted) begin
      // Power-on values come from non-volatile memory and the straps
      s_d.booted = 1'b1;
      s_d.cfg = cfg_nvm_i;
      s_d.own_phase = follower_select_pin_i ? {6'h00, stack_position_i}
                                            : PHASE_LOOP_CTRL;
      s_d.max_phase = {6'h00, stack_size_i};
    end

    if (cmd_event && l_q.tx_cnt == CNT_CMD_DATA) begin
      if (l_q.tx_cmd == CMD_ENABLE_SOURCE && !cfg_bad) begin
        s_d.cfg = l_q.tx_dat[CFG_W-1:0];
      end
      if (l_q.tx_cmd == CMD_PHASE_SELECT && !phase_bad) begin
        s_d.phase = l_q.tx_dat;
      end
    end

    // Set wins over clear so a live fault reappears at once
    s_d.status = (s_q.status & ~clr_vec) | set_vec;
    if (wipe_hits) begin
      s_d.ara_block = '0;
      s_d.alert = 1'b0;
    end
    if (ara_event) begin
      // Only sources set now are silenced; status bits stay
      s_d.ara_block = s_q.status;
      s_d.alert = 1'b0;
    end else if (|(set_vec & ~s_d.ara_block & ~s_q.status)
                 || |(s_q.status & ~s_q.ara_block & ~clr_vec)) begin
      s_d.alert = 1'b1;
    end

    case (s_q.state)
      CONV_OFF: begin
        // Latched-off converter waits for its own release, not a fault clear
        if (want_on && !s_q.latch_s[1]) begin
          s_d.state = CONV_ON;
          s_d.ara_block = '0;
        end
      end
      CONV_ON: begin
        if (s_q.latch_s[1]) begin
          s_d.state = CONV_OFF;
        end else if (!want_on) begin
          if (pin_off && !s_q.cfg[CFG_DELAY_BIT]) begin
            s_d.state = CONV_HOLD;
            s_d.timer = turnoff_hold_time_i;
          end else begin
            s_d.state = CONV_OFF;
          end
        end
      end
      CONV_HOLD: begin
        if (s_q.latch_s[1]) begin
          s_d.state = CONV_OFF;
        end else if (want_on) begin
          s_d.state = CONV_ON;
        end else if (s_q.timer == '0) begin
          s_d.state = CONV_RAMP;
          s_d.timer = turnoff_ramp_time_i;
        end else begin
          s_d.timer = s_q.timer - 1'b1;
        end
      end
      CONV_RAMP: begin
        if (s_q.latch_s[1] || s_q.timer == '0) begin
          s_d.state = CONV_OFF;
        end else if (want_on) begin
          s_d.state = CONV_ON;
        end else begin
          s_d.timer = s_q.timer - 1'b1;
        end
      end
      default: begin
        s_d.state = CONV_OFF;
      end
    endcase

    // Republish readable copy once the link has taken the last one
    if (s_q.ack_s2 == s_q.snap_tgl
        && (s_q.snap_cfg != s_q.cfg || s_q.snap_phase != s_q.phase)) begin
      s_d.snap_cfg = s_q.cfg;
      s_d.snap_phase = s_q.phase;
      s_d.snap_tgl = ~s_q.snap_tgl;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_q <= '0;
      s_q.phase <= PHASE_RESET;
      s_q.snap_phase <= PHASE_RESET;
      s_q.status <= STATUS_RESET;
      s_q.state <= CONV_OFF;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign link_rd_data_o = l_q.rd_data;
  assign alert_n_o = ~s_q.alert;
  assign convert_en_o = s_q.state != CONV_OFF;
  assign ramp_down_o = s_q.state == CONV_RAMP;
  // Lockout only works with the pin obeyed and active high
  assign lockout_active_o = s_q.cfg[CFG_PIN_BIT] && s_q.cfg[CFG_POLARITY_BIT];
  assign phase_select_o = s_q.phase;
  assign phase_match_o = s_q.phase == PHASE_ALL || s_q.phase == s_q.own_phase;
  assign own_phase_o = s_q.own_phase;
  assign status_o = s_q.status;
endmodule

// ==== testbench/pwr_enable_checker.sv ====
// Port-level assertions for the power-enable command logic
module pwr_enable_checker (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic link_clk_i,
  input wire logic link_rd_req_i,
  input wire logic [7:0] link_rd_cmd_i,
  input wire logic [7:0] link_rd_data_o,
  input wire logic link_ara_i,
  input wire logic alert_n_o,
  input wire logic latched_off_i,
  input wire logic [pwr_enable_pkg::FAULT_W-1:0] fault_src_i,
  input wire logic follower_select_pin_i,
  input wire logic [pwr_enable_pkg::TIMER_W-1:0] turnoff_ramp_time_i,
  input wire logic convert_en_o,
  input wire logic ramp_down_o,
  input wire logic [7:0] phase_select_o,
  input wire logic [7:0] own_phase_o,
  input wire logic [pwr_enable_pkg::STATUS_W-1:0] status_o
);
  import pwr_enable_pkg::*;
  // Ramp of ramp_time+1 cycles, then fully off
  sequence s_ramp_then_off;
    ramp_down_o [*4] ##1 (!ramp_down_o && !convert_en_o);
  endsequence
  a_ramp_length: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $rose(ramp_down_o) && turnoff_ramp_time_i == 16'h0003 |-> s_ramp_then_off)
    else $error("ramp length wrong");
  a_latch_off: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    latched_off_i [*5] |-> !convert_en_o) else $error("converting while latched off");
  a_fault_resets: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    fault_src_i[0] [*5] |-> status_o[0]) else $error("live fault missing from status");
  a_ara_releases: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    link_ara_i |-> ##[1:8] alert_n_o) else $error("alert not released");
  a_ara_keeps_bits: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    link_ara_i |-> ##4 (status_o & $past(status_o, 4)) == $past(status_o, 4))
    else $error("status lost on alert response");
  a_phase_legal: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    phase_select_o == PHASE_ALL || phase_select_o <= PHASE_MAX) else $error("illegal phase");
  a_loop_phase: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $past(reset_i, 2) == 1'b0 && !follower_select_pin_i |-> own_phase_o == PHASE_LOOP_CTRL)
    else $error("controller phase wrong");
  a_cfg_top_zero: assert property (@(posedge link_clk_i) disable iff (reset_i)
    link_rd_req_i && link_rd_cmd_i == CMD_ENABLE_SOURCE |=> link_rd_data_o[7:5] == CFG_RSVD_VALUE)
    else $error("config top bits not zero");
endmodule

bind pwr_enable_cmd pwr_enable_checker i_checker (.sys_clk_i, .reset_i, .link_clk_i,
  .link_rd_req_i, .link_rd_cmd_i, .link_rd_data_o, .link_ara_i, .alert_n_o, .latched_off_i,
  .fault_src_i, .follower_select_pin_i, .turnoff_ramp_time_i, .convert_en_o, .ramp_down_o,
  .phase_select_o, .own_phase_o, .status_o);

// ==== testbench/link_host.sv ====
// Link-side host model issuing write, read and alert-response transfers
module link_host (
  input wire logic link_clk_i,
  input wire logic [7:0] rd_data_i,
  output logic start_o,
  output logic valid_o,
  output logic [7:0] byte_o,
  output logic stop_o,
  output logic write_o,
  output logic rd_req_o,
  output logic [7:0] rd_cmd_o,
  output logic ara_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {start_o, valid_o, stop_o, write_o, rd_req_o, ara_o} = 6'h00;
    byte_o = 8'h5A;
    rd_cmd_o = 8'hA5;
  end
  // Byte line shows the inverse once a byte is no longer valid
  task automatic wr(input logic [7:0] c, input logic [7:0] d, input int n);
    @(negedge link_clk_i) start_o = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(negedge link_clk_i) start_o = 1'b0;
      byte_o = (i == 0) ? c : d;
      valid_o = 1'b1;
      @(negedge link_clk_i) valid_o = 1'b0;
      byte_o = ~byte_o;
    end
    stop_o = 1'b1;
    write_o = 1'b1;
    @(negedge link_clk_i) stop_o = 1'b0;
    write_o = 1'b0;
  endtask
  task automatic rd(input logic [7:0] c, output logic [7:0] d);
    @(negedge link_clk_i) rd_req_o = 1'b1;
    rd_cmd_o = c;
    @(negedge link_clk_i) rd_req_o = 1'b0;
    d = rd_data_i;
    rd_cmd_o = ~c;
  endtask
  task automatic ara();
    @(negedge link_clk_i) ara_o = 1'b1;
    @(negedge link_clk_i) ara_o = 1'b0;
  endtask
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench for the power-enable, fault-clear and phase command logic
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pwr_enable_pkg::*;
  logic sys_clk_i = 1'b0;
  logic link_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic input_power_ok_i = 1'b1;
  logic enable_lockout_pin_i = 1'b1;
  logic run_on_i = 1'b1;
  logic latched_off_i = 1'b0;
  logic follower_select_pin_i = 1'b0;
  logic [FAULT_W-1:0] fault_src_i = 7'h00;
  logic [TIMER_W-1:0] turnoff_hold_time_i = 16'h0005;
  logic [TIMER_W-1:0] turnoff_ramp_time_i = 16'h0003;
  logic link_start_i, link_byte_valid_i, link_stop_i, link_write_i, link_rd_req_i, link_ara_i;
  logic [7:0] link_byte_i, link_rd_cmd_i, link_rd_data_o, phase_select_o, own_phase_o;
  logic [STATUS_W-1:0] status_o;
  logic alert_n_o, convert_en_o, ramp_down_o, lockout_active_o, phase_match_o;
  logic [7:0] ph [4] = '{8'h00, 8'h01, 8'h02, 8'hFF};
  logic [7:0] bad [3] = '{8'h03, 8'h04, 8'hFE};
  // Config, pin, run, expected enable
  logic [10:0] rows [9] = '{{8'h1D, 3'b011}, {8'h1D, 3'b000}, {8'h1B, 3'b011}, {8'h1B, 3'b000},
    {8'h17, 3'b101}, {8'h11, 3'b001}, {8'h01, 3'b101}, {8'h1F, 3'b111}, {8'h1D, 3'b110}};
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  initial begin
    #3;
    forever #6 link_clk_i = ~link_clk_i;
  end
  link_host i_host (.link_clk_i, .rd_data_i(link_rd_data_o), .start_o(link_start_i),
    .valid_o(link_byte_valid_i), .byte_o(link_byte_i), .stop_o(link_stop_i),
    .write_o(link_write_i), .rd_req_o(link_rd_req_i), .rd_cmd_o(link_rd_cmd_i), .ara_o(link_ara_i));
  pwr_enable_cmd i_dut (.sys_clk_i, .reset_i, .link_clk_i, .link_start_i, .link_byte_valid_i,
    .link_byte_i, .link_stop_i, .link_write_i, .link_rd_req_i, .link_rd_cmd_i, .link_rd_data_o,
    .link_ara_i, .alert_n_o, .cfg_nvm_i(5'h0A), .input_power_ok_i, .enable_lockout_pin_i,
    .run_on_i, .latched_off_i, .fault_src_i, .follower_select_pin_i,
    .stack_position_i(2'h1), .stack_size_i(2'h2), .turnoff_hold_time_i, .turnoff_ramp_time_i,
    .convert_en_o, .ramp_down_o, .lockout_active_o, .phase_select_o, .phase_match_o,
    .own_phase_o, .status_o);
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask
  // Covers the crossing into the system domain and back
  task automatic settle();
    repeat (14) @(negedge sys_clk_i);
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d, input int n);
    i_host.wr(c, d, n);
    settle();
  endtask
  task automatic rdc(input logic [7:0] c, input logic [7:0] e, input string m);
    logic [7:0] d;
    i_host.rd(c, d);
    chk(d, e, m);
  endtask
  task automatic pin_drop(input int r, input int hmax);
    int nh;
    int nr;
    nh = 0;
    nr = 0;
    enable_lockout_pin_i = 1'b1;
    repeat (30) begin
      @(negedge sys_clk_i);
      nh += int'(convert_en_o && !ramp_down_o);
      nr += int'(ramp_down_o);
    end
    chk(16'(nr), 16'(r), "ramp cycles");
    chk(16'(nh <= hmax && nh >= hmax - 4), 16'h1, "hold cycles");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      test_done();
    end
  end
  initial begin
    repeat (8) @(negedge sys_clk_i);
    reset_i = 1'b0;
    settle();
    chk(phase_select_o, PHASE_RESET, "phase reset");
    chk(convert_en_o, 16'h1, "input power start");
    rdc(CMD_ENABLE_SOURCE, 8'h0A, "cfg reset");
    rdc(CMD_PHASE_SELECT, PHASE_RESET, "phase read reset");
    rdc(8'h10, READ_UNMAPPED, "unmapped read");
    $display("test reset done");
    for (int v = 0; v < 32; v++) begin
      wr(CMD_ENABLE_SOURCE, 8'(v), 2);
      rdc(CMD_ENABLE_SOURCE, 8'(v), "cfg read");
      chk(lockout_active_o, 16'(v[2] & v[1]), "lockout");
    end
    wr(CMD_ENABLE_SOURCE, 8'hE0, 2);
    rdc(CMD_ENABLE_SOURCE, 8'h1F, "bad cfg kept");
    chk({status_o[1], alert_n_o}, 16'h2, "bad cfg flag");
    wr(CMD_FAULT_WIPE, 8'h00, 1);
    // Three bytes: count saturates, so the write is refused
    wr(CMD_ENABLE_SOURCE, 8'h01, 3);
    rdc(CMD_ENABLE_SOURCE, 8'h1F, "long cfg kept");
    chk({status_o[1], alert_n_o}, 16'h2, "long cfg flag");
    wr(CMD_FAULT_WIPE, 8'h00, 1);
    chk({status_o, alert_n_o}, 16'h001, "flag wiped");
    $display("test config done");
    foreach (ph[i]) begin
      wr(CMD_PHASE_SELECT, ph[i], 2);
      chk(phase_select_o, ph[i], "phase");
      chk(phase_match_o, 16'(ph[i] == 8'h00 || ph[i] == 8'hFF), "phase match");
      rdc(CMD_PHASE_SELECT, ph[i], "phase read");
    end
    chk(status_o, STATUS_RESET, "valid phases clean");
    foreach (bad[i]) begin
      wr(CMD_PHASE_SELECT, bad[i], 2);
      chk(phase_select_o, PHASE_ALL, "bad phase kept");
      chk(status_o[1], 16'h1, "bad phase flag");
      wr(CMD_FAULT_WIPE, 8'h00, 1);
    end
    chk(own_phase_o, PHASE_LOOP_CTRL, "own phase");
    $display("test phase done");
    foreach (rows[i]) begin
      {enable_lockout_pin_i, run_on_i} = rows[i][2:1];
      wr(CMD_ENABLE_SOURCE, rows[i][10:3], 2);
      chk(convert_en_o, 16'(rows[i][0]), "enable");
    end
    wr(CMD_ENABLE_SOURCE, 8'h01, 2);
    input_power_ok_i = 1'b0;
    settle();
    chk(convert_en_o, 16'h0, "no input power");
    input_power_ok_i = 1'b1;
    enable_lockout_pin_i = 1'b0;
    wr(CMD_ENABLE_SOURCE, 8'h1C, 2);
    pin_drop(4, 10);
    enable_lockout_pin_i = 1'b0;
    wr(CMD_ENABLE_SOURCE, 8'h1D, 2);
    pin_drop(0, 4);
    $display("test enable done");
    fault_src_i = 7'h01;
    settle();
    wr(CMD_FAULT_WIPE, 8'h00, 1);
    chk({status_o[0], alert_n_o}, 16'h2, "live fault stays");
    fault_src_i = 7'h04;
    settle();
    i_host.ara();
    settle();
    chk({status_o, alert_n_o}, 16'h013, "ara keeps bits");
    fault_src_i = 7'h00;
    settle();
    fault_src_i = 7'h04;
    settle();
    chk(alert_n_o, 16'h1, "old source silent");
    fault_src_i = 7'h0C;
    settle();
    chk({status_o, alert_n_o}, 16'h032, "new source alerts");
    fault_src_i = 7'h00;
    // A clear carrying data is a bad command, not a clear
    wr(CMD_FAULT_WIPE, 8'h00, 2);
    chk(status_o, 16'h01B, "wipe with data refused");
    wr(CMD_FAULT_WIPE, 8'h00, 1);
    chk({status_o, alert_n_o}, 16'h001, "faults wiped");
    $display("test faults done");
    enable_lockout_pin_i = 1'b0;
    settle();
    chk(convert_en_o, 16'h1, "on before latch");
    latched_off_i = 1'b1;
    settle();
    chk(convert_en_o, 16'h0, "latch stops");
    wr(CMD_FAULT_WIPE, 8'h00, 1);
    chk(convert_en_o, 16'h0, "latched stays off");
    $display("test latch done");
    // Second reset with the strap set for a follower at position one
    latched_off_i = 1'b0;
    follower_select_pin_i = 1'b1;
    reset_i = 1'b1;
    repeat (8) @(negedge sys_clk_i);
    reset_i = 1'b0;
    settle();
    chk(own_phase_o, 16'h01, "follower phase");
    wr(8'h10, 8'h00, 2);
    chk(status_o[1], 16'h1, "unknown code flag");
    wr(CMD_PHASE_SELECT, 8'h00, 2);
    chk(phase_match_o, 16'h0, "other phase");
    wr(CMD_FAULT_WIPE, 8'h00, 1);
    chk(status_o[1], 16'h1, "other phase kept");
    wr(CMD_PHASE_SELECT, 8'h01, 2);
    chk(phase_match_o, 16'h1, "own phase match");
    wr(CMD_FAULT_WIPE, 8'h00, 1);
    chk(status_o[1], 16'h0, "own phase wiped");
    $display("test follower done");
    test_done();
  end
endmodule
